// *** tscp_port.sv ***
// Serial command port: receiver, message buffer, transmitter
`timescale 1ns/1ps
`default_nettype none
module tscp_port #(
    parameter int MSG_DEPTH = tscp_pkg::MSG_DEPTH_DEF,
    parameter logic [13:0] PER_4800 = 14'(tscp_pkg::CLK_HZ / tscp_pkg::BAUD_4800),
    parameter logic [13:0] PER_9600 = 14'(tscp_pkg::CLK_HZ / tscp_pkg::BAUD_9600),
    parameter logic [13:0] PER_19200 = 14'(tscp_pkg::CLK_HZ / tscp_pkg::BAUD_19200),
    parameter logic [13:0] PER_38400 = 14'(tscp_pkg::CLK_HZ / tscp_pkg::BAUD_38400)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Configuration
    input wire logic cfg_load_i,
    input wire logic [1:0] cfg_baud_i,
    input wire logic [1:0] cfg_parity_i,
    input wire logic [4:0] cfg_addr_i,
    output logic [4:0] addr_o,
    output logic [1:0] baud_o,
    output logic [1:0] parity_o,
    // Serial pins
    input wire logic rxd_i,
    output logic txd_o,
    // Received message stream
    output logic msg_valid_o,
    input wire logic msg_ready_i,
    output logic [7:0] msg_data_o,
    output logic msg_last_o,
    // Response bytes to send
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    // Status pulses
    output logic frame_err_o,
    output logic parity_err_o,
    output logic overrun_o
);
    import tscp_pkg::*;

    localparam int PW = $clog2(MSG_DEPTH + 1);

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic [1:0] baud_sel;
        logic [1:0] par_sel;
        logic [4:0] addr;
        tscp_rx_t rx_st;
        logic [CNT_W-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_perr;
        tscp_tx_t tx_st;
        logic [CNT_W-1:0] tx_cnt;
        logic [3:0] tx_left;
        logic [10:0] tx_sh;
        logic txd;
        logic [MSG_DEPTH-1:0][7:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] len;
        logic draining;
        logic [1:0][8:0] f_ent;
        logic f_head;
        logic [1:0] f_cnt;
        logic ferr;
        logic perr;
        logic ovr;
    } tscp_state_t;

    tscp_state_t r;
    tscp_state_t next_r;
    logic [CNT_W-1:0] period;
    logic bit_end;
    logic good_byte;
    logic pop;
    logic push;

    // ------------------------------------------------------------
    // Bit period from the selected rate
    // ------------------------------------------------------------
    always_comb
    begin
        case (r.baud_sel)
            BAUD_SEL_4800: period = PER_4800;
            BAUD_SEL_19200: period = PER_19200;
            BAUD_SEL_38400: period = PER_38400;
            default: period = PER_9600;
        endcase
    end

    // Outputs straight from state
    assign addr_o = r.addr;
    assign baud_o = r.baud_sel;
    assign parity_o = r.par_sel;
    assign txd_o = r.txd;
    assign tx_ready_o = (r.tx_st == TX_IDLE);
    assign msg_valid_o = (r.f_cnt != 2'h0);
    assign msg_data_o = r.f_ent[r.f_head][7:0];
    assign msg_last_o = r.f_ent[r.f_head][8];
    assign frame_err_o = r.ferr;
    assign parity_err_o = r.perr;
    assign overrun_o = r.ovr;
    assign bit_end = (r.rx_cnt == period - 14'h0001);
    assign pop = msg_valid_o && msg_ready_i;
    assign push = r.draining && (r.f_cnt != 2'h2);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        good_byte = 1'b0;
        next_r.rx_s1 = rxd_i;
        next_r.rx_s2 = r.rx_s1;
        next_r.ferr = 1'b0;
        next_r.perr = 1'b0;
        next_r.ovr = 1'b0;
        // Local configuration load, address limited to 0..30
        if (cfg_load_i)
        begin
            next_r.baud_sel = cfg_baud_i;
            if (cfg_parity_i != 2'h3)
                next_r.par_sel = cfg_parity_i;
            if (cfg_addr_i <= ADDR_MAX)
                next_r.addr = cfg_addr_i;
        end
        // Receiver with mid-bit sampling
        next_r.rx_cnt = r.rx_cnt + 14'h0001;
        case (r.rx_st)
            RX_IDLE:
            begin
                next_r.rx_cnt = '0;
                if (!r.rx_s2)
                    next_r.rx_st = RX_START;
            end
            RX_START:
            begin
                if (r.rx_cnt == (period >> 1))
                begin
                    next_r.rx_cnt = '0;
                    next_r.rx_bit = '0;
                    next_r.rx_perr = 1'b0;
                    next_r.rx_st = r.rx_s2 ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (bit_end)
                begin
                    next_r.rx_cnt = '0;
                    next_r.rx_sh = {r.rx_s2, r.rx_sh[7:1]};
                    next_r.rx_bit = r.rx_bit + 4'h1;
                    if (r.rx_bit == DATA_BITS - 4'h1)
                        next_r.rx_st = (r.par_sel == PAR_NONE) ? RX_STOP : RX_PAR;
                end
            end
            RX_PAR:
            begin
                if (bit_end)
                begin
                    next_r.rx_cnt = '0;
                    next_r.rx_perr = r.rx_s2 != ((^r.rx_sh) ^ (r.par_sel == PAR_ODD));
                    next_r.rx_st = RX_STOP;
                end
            end
            default:
            begin
                if (bit_end)
                begin
                    next_r.rx_st = RX_IDLE;
                    next_r.ferr = !r.rx_s2;
                    next_r.perr = r.rx_s2 && r.rx_perr;
                    good_byte = r.rx_s2 && !r.rx_perr;
                end
            end
        endcase
        // Message store: collect until newline, then drain
        if (good_byte)
        begin
            if (r.draining)
                next_r.ovr = 1'b1;
            else if (r.wr_ptr == PW'(MSG_DEPTH))
            begin
                next_r.ovr = 1'b1;
                next_r.wr_ptr = '0;
            end
            else
            begin
                next_r.mem[r.wr_ptr] = r.rx_sh;
                next_r.wr_ptr = r.wr_ptr + 1'b1;
                if (r.rx_sh == NEWLINE)
                begin
                    next_r.draining = 1'b1;
                    next_r.len = r.wr_ptr + 1'b1;
                    next_r.rd_ptr = '0;
                end
            end
        end
        // Two-entry output buffer
        if (pop)
            next_r.f_head = !r.f_head;
        if (push)
        begin
            next_r.f_ent[r.f_head ^ r.f_cnt[0]] =
                {(r.rd_ptr + 1'b1 == r.len), r.mem[r.rd_ptr]};
            next_r.rd_ptr = r.rd_ptr + 1'b1;
            if (r.rd_ptr + 1'b1 == r.len)
            begin
                next_r.draining = 1'b0;
                next_r.wr_ptr = '0;
            end
        end
        next_r.f_cnt = r.f_cnt + {1'b0, push} - {1'b0, pop};
        // Transmitter, LSB first, no gating lines
        case (r.tx_st)
            TX_IDLE:
            begin
                next_r.txd = 1'b1;
                next_r.tx_cnt = '0;
                if (tx_valid_i)
                begin
                    next_r.tx_st = TX_SEND;
                    next_r.txd = 1'b0;
                    if (r.par_sel == PAR_NONE)
                    begin
                        next_r.tx_sh = {2'h3, tx_data_i, 1'b0};
                        next_r.tx_left = FRAME_BITS_NOPAR;
                    end
                    else
                    begin
                        next_r.tx_sh = {1'b1, (^tx_data_i) ^ (r.par_sel == PAR_ODD),
                            tx_data_i, 1'b0};
                        next_r.tx_left = FRAME_BITS_PAR;
                    end
                end
            end
            default:
            begin
                next_r.tx_cnt = r.tx_cnt + 14'h0001;
                if (r.tx_cnt == period - 14'h0001)
                begin
                    next_r.tx_cnt = '0;
                    next_r.tx_sh = {1'b1, r.tx_sh[10:1]};
                    next_r.txd = r.tx_sh[1];
                    next_r.tx_left = r.tx_left - 4'h1;
                    if (r.tx_left == 4'h1)
                    begin
                        next_r.tx_st = TX_IDLE;
                        next_r.txd = 1'b1;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= '0;
            r.rx_s1 <= 1'b1;
            r.rx_s2 <= 1'b1;
            r.baud_sel <= BAUD_SEL_DEF;
            r.par_sel <= PAR_DEF;
            r.addr <= ADDR_DEF;
            r.rx_st <= RX_IDLE;
            r.tx_st <= TX_IDLE;
            r.txd <= 1'b1;
        end
        else
            r <= next_r;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_addr_range: assert property (r.addr <= ADDR_MAX)
        else $error("address above 30");
    a_baud_default: assert property ($rose(arst_n_i) |-> r.baud_sel == BAUD_SEL_DEF)
        else $error("rate not 9600 after reset");
    a_parity_legal: assert property (r.par_sel != 2'h3)
        else $error("illegal parity setting");
    a_tx_start: assert property (tx_valid_i && tx_ready_o |=> !txd_o && !tx_ready_o)
        else $error("no start bit");
    a_tx_stop: assert property ($rose(tx_ready_o) |-> txd_o && $past(txd_o))
        else $error("stop bit missing");
    a_last_newline: assert property (msg_valid_o && msg_last_o |-> msg_data_o == NEWLINE)
        else $error("message not ended by newline");
    a_no_gating: assert property (r.tx_st == TX_IDLE && tx_valid_i |=> r.tx_st == TX_SEND)
        else $error("send gated");
    a_frame_drop: assert property (r.rx_st == RX_STOP && bit_end && !r.rx_s2
        |=> frame_err_o && $stable(r.wr_ptr))
        else $error("bad frame kept");
    a_drain_hold: assert property (r.draining && $past(r.draining) |-> $stable(r.len))
        else $error("message changed while handed over");
    a_addr_keep: assert property (cfg_load_i && cfg_addr_i > ADDR_MAX |=> $stable(addr_o))
        else $error("out of range address taken");

    c_message: cover property (pop && msg_last_o);
    c_parity_err: cover property (parity_err_o);
    c_buffer_full: cover property (r.f_cnt == 2'h2 && !msg_ready_i);
    c_tx_parity: cover property (tx_valid_i && tx_ready_o && r.par_sel == PAR_ODD);
endmodule // tscp_port
`default_nettype wire

// *** tscp_pkg.sv ***
// Constants and types of the serial command port
package tscp_pkg;
    // ------------------------------------------------------------
    // Clock and bit rates
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int CNT_W = 14;
    // ------------------------------------------------------------
    // Configuration encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] BAUD_SEL_4800 = 2'h0;
    localparam logic [1:0] BAUD_SEL_9600 = 2'h1;
    localparam logic [1:0] BAUD_SEL_19200 = 2'h2;
    localparam logic [1:0] BAUD_SEL_38400 = 2'h3;
    localparam logic [1:0] BAUD_SEL_DEF = BAUD_SEL_9600;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_DEF = PAR_NONE;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] ADDR_DEF = 5'h00;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [7:0] NEWLINE = 8'h0a;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] FRAME_BITS_NOPAR = 4'ha;
    localparam logic [3:0] FRAME_BITS_PAR = 4'hb;
    localparam int MSG_DEPTH_DEF = 64;
    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } tscp_rx_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SEND = 2'h2
    } tscp_tx_t;
endpackage : tscp_pkg

// *** tscp_host.sv ***
// Host-side serial model facing the command port pins
`timescale 1ns/1ps
`default_nettype none
module tscp_host (
    // Clock and serial pins
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    // Line idles high between frames
    initial rxd_o = 1'b1;

    // Sends one frame; errs[0] corrupts parity, errs[1] pulls the stop bit low
    task automatic send(input logic [7:0] b, input logic [1:0] par, input int per,
        input logic [1:0] errs);
        logic [10:0] f;
        int n;
        f = {2'h3, b, 1'b0};
        n = 10;
        if (par != 2'h0)
        begin
            f = {1'b1, (^b ^ par[1]) ^ errs[0], b, 1'b0};
            n = 11;
        end
        if (errs[1])
            f[n - 1] = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            rxd_o <= f[i];
            repeat (per) @(posedge clk_i);
        end
        // One idle bit between characters
        rxd_o <= 1'b1;
        repeat (per) @(posedge clk_i);
    endtask

    // Receives one frame at mid-bit, flags a bad start, parity or stop
    task automatic recv(input logic [1:0] par, input int per, output logic [7:0] b,
        output logic ok);
        int t;
        t = 0;
        b = 8'h00;
        while (txd_i !== 1'b0 && t < 6000)
        begin
            @(posedge clk_i);
            t++;
        end
        repeat (per / 2) @(posedge clk_i);
        ok = (txd_i === 1'b0) && (t < 6000);
        for (int i = 0; i < 8; i++)
        begin
            repeat (per) @(posedge clk_i);
            b[i] = txd_i;
        end
        if (par != 2'h0)
        begin
            repeat (per) @(posedge clk_i);
            if (txd_i !== (^b ^ par[1]))
                ok = 1'b0;
        end
        repeat (per) @(posedge clk_i);
        if (txd_i !== 1'b1)
            ok = 1'b0;
    endtask
endmodule // tscp_host
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the serial command port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tscp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int DEPTH = 4;
    int per_tab [4] = '{40, 32, 24, 16};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfg_load = 1'b0;
    logic [1:0] cfg_baud = 2'h0;
    logic [1:0] cfg_parity = 2'h0;
    logic [4:0] cfg_addr = 5'h00;
    logic [4:0] addr;
    logic [1:0] baud;
    logic [1:0] parity;
    logic rxd;
    logic txd;
    logic m_valid;
    logic m_ready = 1'b0;
    logic [7:0] m_data;
    logic m_last;
    logic t_valid = 1'b0;
    logic t_ready;
    logic [7:0] t_data = 8'h00;
    logic f_err;
    logic p_err;
    logic ovr;
    logic [2:0] seen = 3'h0;
    logic [7:0] rb;
    logic ok;
    int error_cnt = 0;
    int cmp_count = 0;

    // Clock and sticky capture of status pulses
    always #12.5 clk = ~clk;
    always @(posedge clk) seen <= seen | {ovr, f_err, p_err};

    tscp_port #(.MSG_DEPTH(DEPTH), .PER_4800(14'h0028), .PER_9600(14'h0020),
        .PER_19200(14'h0018), .PER_38400(14'h0010)) uut (
        .ref_clk_i(clk), .arst_n_i(arst_n), .cfg_load_i(cfg_load), .cfg_baud_i(cfg_baud),
        .cfg_parity_i(cfg_parity), .cfg_addr_i(cfg_addr), .addr_o(addr), .baud_o(baud),
        .parity_o(parity), .rxd_i(rxd), .txd_o(txd), .msg_valid_o(m_valid),
        .msg_ready_i(m_ready), .msg_data_o(m_data), .msg_last_o(m_last),
        .tx_valid_i(t_valid), .tx_ready_o(t_ready), .tx_data_i(t_data),
        .frame_err_o(f_err), .parity_err_o(p_err), .overrun_o(ovr));
    tscp_host host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cfg(input logic [1:0] bs, input logic [1:0] ps, input logic [4:0] ad);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_baud <= bs;
        cfg_parity <= ps;
        cfg_addr <= ad;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tx(input logic [7:0] d);
        int t;
        t = 0;
        while (t_ready !== 1'b1 && t < 6000)
        begin
            @(negedge clk);
            t++;
        end
        @(posedge clk);
        t_valid <= 1'b1;
        t_data <= d;
        @(posedge clk);
        t_valid <= 1'b0;
    endtask

    // Takes one message byte; stall keeps ready low a while first
    task automatic drain(input logic [7:0] exp, input logic last, input logic stall);
        int t;
        t = 0;
        @(negedge clk);
        while (m_valid !== 1'b1 && t < 3000)
        begin
            @(negedge clk);
            t++;
        end
        chk(m_valid, 1'b1);
        chk(m_data, exp);
        chk(m_last, last);
        if (stall)
        begin
            repeat (6) @(negedge clk);
            chk(m_data, exp);
        end
        @(posedge clk);
        m_ready <= 1'b1;
        @(posedge clk);
        m_ready <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(addr, ADDR_DEF);
        chk(baud, BAUD_SEL_DEF);
        chk(parity, PAR_DEF);
        chk(txd, 1'b1);
        chk(t_ready, 1'b1);
        chk(m_valid, 1'b0);
        cfg(BAUD_SEL_9600, PAR_NONE, ADDR_MAX);
        chk(addr, 8'h1e);
        cfg(BAUD_SEL_9600, 2'h3, 5'h1f);
        chk(addr, 8'h1e);
        chk(parity, PAR_NONE);
        // Every rate and parity mode, both directions
        for (int b = 0; b < 4; b++)
            for (int p = 0; p < 3; p++)
            begin
                cfg(2'(b), 2'(p), 5'(b * 3 + p));
                chk(baud, 8'(b));
                chk(parity, 8'(p));
                chk(addr, 8'(b * 3 + p));
                fork
                    tx(8'ha5 ^ 8'(b * 4 + p));
                    host.recv(2'(p), per_tab[b], rb, ok);
                join
                chk(rb, 8'ha5 ^ 8'(b * 4 + p));
                chk(ok, 1'b1);
                host.send(8'h30 + 8'(b * 4 + p), 2'(p), per_tab[b], 2'h0);
                chk(m_valid, 1'b0);
                host.send(NEWLINE, 2'(p), per_tab[b], 2'h0);
                drain(8'h30 + 8'(b * 4 + p), 1'b0, 1'b0);
                drain(NEWLINE, 1'b1, b == 3);
            end
        // Bad parity and bad stop characters are dropped
        cfg(BAUD_SEL_38400, PAR_EVEN, 5'h00);
        seen = 3'h0;
        host.send(8'h11, PAR_EVEN, 16, 2'h1);
        chk(seen[0], 1'b1);
        host.send(8'h22, PAR_EVEN, 16, 2'h2);
        chk(seen[1], 1'b1);
        host.send(8'h33, PAR_EVEN, 16, 2'h0);
        host.send(NEWLINE, PAR_EVEN, 16, 2'h0);
        drain(8'h33, 1'b0, 1'b0);
        drain(NEWLINE, 1'b1, 1'b0);
        // Converter setting; a byte past a full buffer discards the message
        cfg(BAUD_SEL_38400, PAR_NONE, ADDR_MAX);
        chk(baud, BAUD_SEL_38400);
        chk(parity, PAR_NONE);
        seen = 3'h0;
        for (int i = 0; i <= DEPTH; i++)
            host.send(8'h40 + 8'(i), PAR_NONE, 16, 2'h0);
        chk(seen[2], 1'b1);
        chk(m_valid, 1'b0);
        host.send(NEWLINE, PAR_NONE, 16, 2'h0);
        drain(NEWLINE, 1'b1, 1'b0);
        test_done();
    end

    // Watchdog
    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule // tb
`default_nettype wire
